// ==== hw/cmmsp_pkg.sv ====
// shared constants, word layout and helpers for the cascade serial port
package cmmsp_pkg;
	localparam int          WORD_W     = 16;
	localparam int          N_CHAN     = 2;
	// control word layout
	localparam int          CTRL_BIT   = 15;
	localparam int          RDBK_BIT   = 14;
	localparam int          DADDR_LO   = 11;
	localparam int          RADDR_LO   = 8;
	// channel register indices
	localparam logic [2:0]  REG_A      = 3'h0;
	localparam logic [2:0]  REG_B      = 3'h1;
	localparam logic [2:0]  REG_C      = 3'h2;
	localparam logic [7:0]  REG_RESET  = 8'h00;
	// register A fields
	localparam int          A_PGM      = 0;
	localparam int          A_MIXED    = 1;
	localparam int          A_DCNT_LO  = 4;
	// register B fields
	localparam int          B_SCLK_LO  = 0;
	localparam int          B_SRATE_LO = 2;
	localparam int          B_MDIV_LO  = 4;
	// register C fields
	localparam int          C_PWR      = 0;
	// divider bases in internal master clock cycles
	localparam int          SMP_BASE   = 256;
	localparam int          SCLK_BASE  = 2;
	// host register offsets and reset values
	localparam logic [7:0]  H_CTRL     = 8'h00;
	localparam logic [7:0]  H_STATUS   = 8'h04;
	localparam logic [7:0]  H_TXDATA   = 8'h08;
	localparam logic [7:0]  H_RXDATA   = 8'h0C;
	localparam int          HC_LOOP    = 0;
	localparam int          HS_TXPEND  = 0;
	localparam int          HS_TXBUSY  = 1;
	localparam int          HS_RXVALID = 2;
	localparam int          HS_OVERRUN = 3;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	typedef logic [WORD_W-1:0] cmmsp_word_t;

	// step the device address field down by one, wrapping 000 to 111
	function automatic cmmsp_word_t cmmsp_dec_addr(input cmmsp_word_t w);
		cmmsp_word_t r;
		r = w;
		r[DADDR_LO +: 3] = w[DADDR_LO +: 3] - 3'h1;
		return r;
	endfunction : cmmsp_dec_addr
endpackage : cmmsp_pkg

// ==== hw/cmmsp_link_if.sv ====
// serial link between the host port and the two-channel cascade
interface cmmsp_link_if;
	logic sclk_tick;
	logic serial_in;
	logic in_frame_sync;
	logic serial_out;
	logic out_frame_sync;

	modport device (
		output sclk_tick,
		output serial_out,
		output out_frame_sync,
		input  serial_in,
		input  in_frame_sync
	);
	modport host (
		input  sclk_tick,
		input  serial_out,
		input  out_frame_sync,
		output serial_in,
		output in_frame_sync
	);
endinterface : cmmsp_link_if

// ==== hw/cmmsp_device.sv ====
// device end: two cascaded channel serial ports with shared clock dividers

module cmmsp_device (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	cmmsp_link_if.device                link,
	input  wire logic [1:0][15:0]       adc_sample,
	output logic      [1:0][15:0]       dac_word,
	output logic      [1:0]             dac_strobe,
	output logic      [1:0]             analog_power
);
	localparam int N = cmmsp_pkg::N_CHAN;

	logic [2:0]   dm_cnt;
	logic [3:0]   sc_cnt;
	logic [10:0]  sm_cnt;
	logic         tick;
	logic         sample_evt;
	logic [7:0]   regb;
	logic [N-1:0] out_bit;
	logic [N-1:0] out_fs;

	// clocks follow channel 0, the first to receive host words; both hold equal values after a cascade write
	wire logic [2:0]   mdiv     = regb[cmmsp_pkg::B_MDIV_LO +: 3];
	wire logic [1:0]   sclk_sel = regb[cmmsp_pkg::B_SCLK_LO +: 2];
	wire logic [1:0]   srate    = regb[cmmsp_pkg::B_SRATE_LO +: 2];
	wire logic         dm_en    = (dm_cnt >= mdiv);
	wire logic [3:0]   sc_lim   = 4'((cmmsp_pkg::SCLK_BASE << sclk_sel) - 1);
	wire logic [10:0]  sm_lim   = 11'((cmmsp_pkg::SMP_BASE << srate) - 1);
	wire logic [N-1:0] chain_bit = {out_bit[N-2:0], link.serial_in};
	wire logic [N-1:0] chain_fs  = {out_fs[N-2:0], link.in_frame_sync};

	// dividers: internal master clock, serial tick, sample event
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dm_cnt <= 3'h0;
			sc_cnt <= 4'h0;
			sm_cnt <= 11'h000;
			tick <= 1'b0;
			sample_evt <= 1'b0;
		end
		else
		begin
			dm_cnt <= dm_en ? 3'h0 : dm_cnt + 3'h1;
			tick <= dm_en && (sc_cnt >= sc_lim);
			sample_evt <= dm_en && (sm_cnt >= sm_lim);
			if (dm_en)
			begin
				sc_cnt <= (sc_cnt >= sc_lim) ? 4'h0 : sc_cnt + 4'h1;
				sm_cnt <= (sm_cnt >= sm_lim) ? 11'h000 : sm_cnt + 11'h001;
			end
		end
	end

	assign link.sclk_tick = tick;
	assign link.serial_out = out_bit[N-1];
	assign link.out_frame_sync = out_fs[N-1];

	for (genvar c = 0; c < N; c++)
	begin : g_chan
		logic [15:0] tx_sr;
		logic [3:0]  tx_cnt;
		logic [15:0] rx_sr;
		logic [3:0]  rx_cnt;
		logic [2:0]  fs_cnt;
		logic        pend;
		logic        ob;
		logic        ofs;
		logic [15:0] dac_q;
		logic        upd;
		logic [7:0]  regs [8];

		wire logic [15:0] rw      = {rx_sr[14:0], chain_bit[c]};
		wire logic        rx_done = tick && (rx_cnt == 4'hF);
		wire logic [7:0]  rega    = regs[cmmsp_pkg::REG_A];
		wire logic        pgm     = rega[cmmsp_pkg::A_PGM];
		wire logic        mixed   = rega[cmmsp_pkg::A_MIXED];
		// msb one is control outside program mode or in mixed mode; in mixed mode only msb zero is data
		wire logic        is_ctrl = rw[cmmsp_pkg::CTRL_BIT] && (!pgm || mixed);
		wire logic        is_dac  = pgm && (!mixed || !rw[cmmsp_pkg::CTRL_BIT]);
		wire logic        here    = is_ctrl && (rw[cmmsp_pkg::DADDR_LO +: 3] == 3'h0);
		wire logic        rdbk    = here && rw[cmmsp_pkg::RDBK_BIT];
		wire logic        wr      = here && !rw[cmmsp_pkg::RDBK_BIT];
		wire logic        hit     = is_dac && (fs_cnt == rega[cmmsp_pkg::A_DCNT_LO +: 3]);
		wire logic [2:0]  raddr   = rw[cmmsp_pkg::RADDR_LO +: 3];
		wire logic [15:0] rb_word = {2'b11, 3'h0, raddr, regs[raddr]};
		// everything not consumed here goes downstream
		wire logic        send    = rx_done && !wr && !hit;
		wire logic [15:0] fwd     = rdbk    ? cmmsp_pkg::cmmsp_dec_addr(rb_word)
		                          : is_ctrl ? cmmsp_pkg::cmmsp_dec_addr(rw)
		                          : rw;
		wire logic        tx_idle = (tx_cnt == 4'h0);
		wire logic        start_smp = tick && !send && pend && tx_idle;
		wire logic        start   = (tick && send) || start_smp;
		wire logic [15:0] tx_word = send ? fwd : adc_sample[c];

		// receive shifter, word framed by the incoming frame sync
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				rx_sr <= cmmsp_pkg::WORD_RESET;
				rx_cnt <= 4'h0;
			end
			else if (tick)
			begin
				if (rx_cnt != 4'h0 || chain_fs[c])
				begin
					rx_sr <= {rx_sr[14:0], chain_bit[c]};
					rx_cnt <= rx_cnt + 4'h1;
				end
			end
		end

		// transmit shifter; a forward preempts a late sample word, which waits
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				tx_sr <= cmmsp_pkg::WORD_RESET;
				tx_cnt <= 4'h0;
				ob <= 1'b0;
				ofs <= 1'b0;
				pend <= 1'b0;
			end
			else
			begin
				pend <= sample_evt || (pend && !start_smp);
				if (start)
				begin
					ob <= tx_word[15];
					ofs <= 1'b1;
					tx_sr <= {tx_word[14:0], 1'b0};
					tx_cnt <= 4'hF;
				end
				else if (tick)
				begin
					ofs <= 1'b0;
					if (!tx_idle)
					begin
						ob <= tx_sr[15];
						tx_sr <= {tx_sr[14:0], 1'b0};
						tx_cnt <= tx_cnt - 4'h1;
					end
				end
			end
		end

		// register writes and DAC update counting
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				for (int i = 0; i < 8; i++)
					regs[i] <= cmmsp_pkg::REG_RESET;
				fs_cnt <= 3'h0;
				dac_q <= cmmsp_pkg::WORD_RESET;
				upd <= 1'b0;
			end
			else
			begin
				upd <= 1'b0;
				if (rx_done && wr)
					regs[raddr] <= rw[7:0];
				if (rx_done && is_dac)
				begin
					if (hit)
					begin
						dac_q <= rw;
						upd <= 1'b1;
						fs_cnt <= 3'h0;
					end
					else
						fs_cnt <= fs_cnt + 3'h1;
				end
			end
		end

		assign out_bit[c] = ob;
		assign out_fs[c] = ofs;
		assign dac_word[c] = dac_q;
		assign dac_strobe[c] = upd;
		assign analog_power[c] = regs[cmmsp_pkg::REG_C][cmmsp_pkg::C_PWR];
		if (c == 0)
		begin : g_clk_src
			assign regb = regs[cmmsp_pkg::REG_B];
		end
	end
endmodule : cmmsp_device

// ==== hw/cmmsp_host.sv ====
// host end: serial port of the controlling processor with an APB register slave
module cmmsp_host #(
	parameter int ADDR_W = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	cmmsp_link_if.host             link
);
	logic        loop_en;
	logic [15:0] tx_hold;
	logic        tx_pend;
	logic [15:0] tx_sr;
	logic [3:0]  tx_cnt;
	logic        tx_bit;
	logic        tx_fs;
	logic [15:0] rx_sr;
	logic [3:0]  rx_cnt;
	logic [15:0] rx_data;
	logic        rx_valid;
	logic        overrun;

	wire logic [7:0]  a8      = 8'(paddr);
	wire logic        s_ctrl  = (a8 == cmmsp_pkg::H_CTRL);
	wire logic        s_stat  = (a8 == cmmsp_pkg::H_STATUS);
	wire logic        s_txd   = (a8 == cmmsp_pkg::H_TXDATA);
	wire logic        s_rxd   = (a8 == cmmsp_pkg::H_RXDATA);
	wire logic        mapped  = s_ctrl || s_stat || s_txd || s_rxd;
	wire logic        setup   = psel && !penable;
	wire logic        acc     = psel && penable && pready;
	wire logic        wr      = acc && pwrite && mapped;
	wire logic        rd_rx   = acc && !pwrite && s_rxd;
	wire logic        tick    = link.sclk_tick;
	wire logic        tx_idle = (tx_cnt == 4'h0);
	wire logic        rx_first = tick && (rx_cnt == 4'h0) && link.out_frame_sync;
	wire logic        rx_done = tick && (rx_cnt == 4'hF);
	wire logic [15:0] rx_word = {rx_sr[14:0], link.serial_out};
	// loopback: every word from the cascade triggers exactly one word back
	wire logic        start   = loop_en ? rx_first : (tick && tx_idle && tx_pend);
	wire logic [15:0] tx_word = tx_pend ? tx_hold : cmmsp_pkg::WORD_RESET;
	wire logic [31:0] status  = {28'h0000000, overrun, rx_valid, !tx_idle, tx_pend};
	wire logic [31:0] rd_mux  = s_ctrl ? {31'h00000000, loop_en}
	                          : s_stat ? status
	                          : s_txd  ? {16'h0000, tx_hold}
	                          : s_rxd  ? {16'h0000, rx_data}
	                          : 32'h00000000;

	// zero-wait slave: data captured in setup, answered in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup;
			prdata <= (setup && !pwrite) ? rd_mux : 32'h00000000;
			pslverr <= setup && !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			loop_en <= 1'b0;
			tx_hold <= cmmsp_pkg::WORD_RESET;
			tx_pend <= 1'b0;
		end
		else
		begin
			if (wr && s_ctrl)
				loop_en <= pwdata[cmmsp_pkg::HC_LOOP];
			if (wr && s_txd)
				tx_hold <= pwdata[15:0];
			// a new word written in the consuming cycle stays pending
			tx_pend <= (wr && s_txd) || (tx_pend && !start);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_sr <= cmmsp_pkg::WORD_RESET;
			tx_cnt <= 4'h0;
			tx_bit <= 1'b0;
			tx_fs <= 1'b0;
		end
		else if (start)
		begin
			tx_bit <= tx_word[15];
			tx_fs <= 1'b1;
			tx_sr <= {tx_word[14:0], 1'b0};
			tx_cnt <= 4'hF;
		end
		else if (tick)
		begin
			tx_fs <= 1'b0;
			if (!tx_idle)
			begin
				tx_bit <= tx_sr[15];
				tx_sr <= {tx_sr[14:0], 1'b0};
				tx_cnt <= tx_cnt - 4'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_sr <= cmmsp_pkg::WORD_RESET;
			rx_cnt <= 4'h0;
			rx_data <= cmmsp_pkg::WORD_RESET;
			rx_valid <= 1'b0;
			overrun <= 1'b0;
		end
		else
		begin
			if (tick && (rx_cnt != 4'h0 || link.out_frame_sync))
			begin
				rx_sr <= rx_word;
				rx_cnt <= rx_cnt + 4'h1;
			end
			if (rx_done)
				rx_data <= rx_word;
			// arrival wins over the read that clears it
			rx_valid <= rx_done || (rx_valid && !rd_rx);
			overrun <= (rx_done && rx_valid && !rd_rx)
			        || (overrun && !(wr && s_stat && pwdata[cmmsp_pkg::HS_OVERRUN]));
		end
	end

	assign link.serial_in = tx_bit;
	assign link.in_frame_sync = tx_fs;
endmodule : cmmsp_host

// ==== dv/cmmsp_link_props.sv ====
// link checker for the cascade serial port
module cmmsp_link_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sclk_tick,
	input wire logic serial_in,
	input wire logic in_frame_sync,
	input wire logic serial_out,
	input wire logic out_frame_sync
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       out_fs_q;
	logic       in_fs_q;
	logic [4:0] out_ticks;
	logic [4:0] in_ticks;
	logic [9:0] gap;
	wire        out_rise = out_frame_sync & ~out_fs_q;
	wire        in_rise  = in_frame_sync & ~in_fs_q;
	// ticks since the last word start, saturating so a long idle never wraps
	wire  [4:0] next_out_ticks = out_rise ? {4'h0, sclk_tick} :
		(sclk_tick && out_ticks != 5'h1F) ? out_ticks + 5'h01 : out_ticks;
	wire  [4:0] next_in_ticks = in_rise ? {4'h0, sclk_tick} :
		(sclk_tick && in_ticks != 5'h1F) ? in_ticks + 5'h01 : in_ticks;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_fs_q  <= 1'b0;
			in_fs_q   <= 1'b0;
			out_ticks <= 5'h10;
			in_ticks  <= 5'h10;
			gap       <= 10'h000;
		end
		else
		begin
			out_fs_q  <= out_frame_sync;
			in_fs_q   <= in_frame_sync;
			out_ticks <= next_out_ticks;
			in_ticks  <= next_in_ticks;
			gap       <= out_rise ? 10'h000 : gap + 10'h001;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	out_fs_tick_a: assert property ($changed(out_frame_sync) |-> $past(sclk_tick))
		else $error("device frame sync moved between ticks");
	in_fs_tick_a: assert property (($changed(in_frame_sync) || $changed(serial_in)) |-> $past(sclk_tick))
		else $error("host link lines moved between ticks");
	out_fs_once_a: assert property (out_frame_sync && sclk_tick |=> !out_frame_sync)
		else $error("device frame sync longer than one bit");
	in_fs_once_a: assert property (in_frame_sync && sclk_tick |=> !in_frame_sync)
		else $error("host frame sync longer than one bit");
	tick_pulse_a: assert property (sclk_tick |=> !sclk_tick ##1 sclk_tick)
		else $error("serial tick not at half the clock rate");
	out_word_gap_a: assert property (out_rise |-> out_ticks >= 5'h10)
		else $error("device word shorter than 16 bits");
	in_word_gap_a: assert property (in_rise |-> in_ticks >= 5'h10)
		else $error("host word shorter than 16 bits");
	sample_due_a: assert property (gap < 10'h12C)
		else $error("no device word start within a sample period");
endmodule : cmmsp_link_props

// ==== dv/tb.sv ====
// self-checking bench: host and cascade joined over the serial link
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic             pclk;
	logic             presetn;
	logic             psel;
	logic             penable;
	logic             pwrite;
	logic [7:0]       paddr;
	logic [31:0]      pwdata;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic [1:0][15:0] adc_sample;
	logic [1:0][15:0] dac_word;
	logic [1:0]       dac_strobe;
	logic [1:0]       analog_power;
	logic [31:0]      rd;
	logic             err;
	int               n_mismatch;
	int               n_tests;

	cmmsp_link_if link ();
	cmmsp_device u_cmmsp_device (.pclk(pclk), .presetn(presetn), .link(link), .adc_sample(adc_sample),
		.dac_word(dac_word), .dac_strobe(dac_strobe), .analog_power(analog_power));
	cmmsp_host #(.ADDR_W(8)) u_cmmsp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(link));
	cmmsp_link_props u_cmmsp_link_props (.pclk(pclk), .presetn(presetn), .sclk_tick(link.sclk_tick),
		.serial_in(link.serial_in), .in_frame_sync(link.in_frame_sync), .serial_out(link.serial_out),
		.out_frame_sync(link.out_frame_sync));

	always #4 pclk = ~pclk;

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	task automatic hang();
		n_mismatch++;
		summarize();
	endtask : hang

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_mismatch++;
		end
	endtask : chk

	// entered and left just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			hang();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic poll(input int bit_idx, input logic val);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, cmmsp_pkg::H_STATUS, 32'h0);
			n++;
		end
		while (rd[bit_idx] !== val && n < 500);
		if (n >= 500)
			hang();
	endtask : poll

	task automatic get_rx(input logic [15:0] exp);
		poll(cmmsp_pkg::HS_RXVALID, 1'b1);
		apb(1'b0, cmmsp_pkg::H_RXDATA, 32'h0);
		chk(rd, {16'h0000, exp});
	endtask : get_rx

	// nearer channel's sample first, then the forwarded one
	task automatic rx_pair();
		get_rx(16'h5678);
		get_rx(16'h1234);
	endtask : rx_pair

	// waiting for an empty hold keeps the next word back to back
	task automatic send(input logic [15:0] w);
		poll(cmmsp_pkg::HS_TXPEND, 1'b0);
		apb(1'b1, cmmsp_pkg::H_TXDATA, {16'h0000, w});
	endtask : send

	task automatic wait_dac(input logic [1:0] es, input logic [15:0] e1, input logic [15:0] e0);
		int n;
		n = 0;
		do
		begin
			@(negedge pclk);
			n++;
		end
		while (dac_strobe === 2'b00 && n < 3000);
		if (n >= 3000)
			hang();
		chk({30'h0, dac_strobe}, {30'h0, es});
		chk({dac_word[1], dac_word[0]}, {e1, e0});
		@(posedge pclk);
	endtask : wait_dac

	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		adc_sample = {16'h5678, 16'h1234};
		n_mismatch = 0;
		n_tests = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, cmmsp_pkg::H_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("test reset done");
		rx_pair();
		chk({30'h0, analog_power}, 32'h0);
		send(16'h8813);
		send(16'h8013);
		$display("test mixed entry done");
		rx_pair();
		send(16'h8A01);
		send(16'h8201);
		send(16'h0AAA);
		send(16'h0555);
		wait_dac(2'b11, 16'h0AAA, 16'h0555);
		chk({30'h0, analog_power}, 32'h3);
		$display("test control and dac done");
		rx_pair();
		send(16'h0F0F);
		send(16'h00F0);
		wait_dac(2'b11, 16'h0F0F, 16'h00F0);
		$display("test dac repeat done");
		rx_pair();
		send(16'hC800);
		send(16'hC000);
		get_rx(16'hF813);
		get_rx(16'hF013);
		$display("test readback done");
		// channel 1 already counted one sample word, so the next one from channel 0 updates it alone
		wait_dac(2'b10, 16'h1234, 16'h00F0);
		get_rx(16'h5678);
		$display("test sample count done");
		// loopback: one zero word per device word, so both channels update together
		apb(1'b1, cmmsp_pkg::H_CTRL, 32'h00000001);
		wait_dac(2'b11, 16'h0000, 16'h0000);
		apb(1'b0, cmmsp_pkg::H_RXDATA, 32'h0);
		chk(rd, 32'h00001234);
		$display("test loopback done");
		summarize();
	end
endmodule : tb
